/* File: rtl/enc_pkg.sv */
// constants, types and helper functions for the incremental encoder interface
package enc_pkg;

	// ************************************************
	// register map, word aligned byte addresses
	// ************************************************
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_IO = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;
	localparam logic [7:0] ADDR_POS = 8'h0c;
	localparam logic [7:0] ADDR_IDX = 8'h10;
	localparam logic [7:0] ADDR_TMR = 8'h14;
	localparam logic [7:0] ADDR_VEL = 8'h18;
	localparam logic [7:0] ADDR_INIT = 8'h1c;
	localparam logic [7:0] ADDR_LEC = 8'h20;

	// ************************************************
	// field positions and masks
	// ************************************************
	localparam int CTL_EN = 15;
	localparam int CTL_SIDL = 13;
	localparam int CTL_PIMOD_LSB = 10;
	localparam int CTL_IMV_B = 9;
	localparam int CTL_IMV_A = 8;
	localparam int CTL_DIV_LSB = 4;
	localparam int CTL_DIRSEL = 3;
	localparam int CTL_GATE_ENABLE = 2;
	localparam int CTL_CCM_LSB = 0;
	localparam logic [15:0] CTRL_WMASK = 16'hbf7f;  // bits 14 and 7 read as zero
	localparam int IO_LSB = 4;  // io control field sits above the four pin levels
	localparam int IO_SWAP = 0;
	localparam int IO_A_INV = 1;
	localparam int IO_B_INV = 2;
	localparam int IO_IDX_INV = 3;
	localparam int IO_HOME_INV = 4;
	localparam int STAT_DONE = 0;
	localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
	localparam logic [6:0] PRE_ONES = 7'h7f;

	// ************************************************
	// modes and states
	// ************************************************
	typedef enum logic [1:0] {
		CCM_QUAD = 2'b00,
		CCM_EXT_DIR = 2'b01,
		CCM_EXT_CLK = 2'b10,
		CCM_INT_TMR = 2'b11
	} enc_ccm_e;

	typedef enum logic [2:0] {
		PIM_NONE = 3'b000,
		PIM_INDEX_RESET = 3'b001,
		PIM_NEXT = 3'b010,
		PIM_HOME_FIRST = 3'b011,
		PIM_HOME_SECOND = 3'b100,
		PIM_GE_RESET = 3'b101,
		PIM_MODULO = 3'b110,
		PIM_RESERVED = 3'b111
	} enc_pimod_e;

	typedef enum logic [2:0] {
		HM_IDLE = 3'b001,
		HM_HOMED = 3'b010,
		HM_ONE = 3'b100
	} enc_home_e;

	// ************************************************
	// carriers
	// ************************************************
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} enc_apb_req_s;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} enc_apb_rsp_s;

	typedef struct packed {
		logic phase_a_input;
		logic phase_b_input;
		logic index;
		logic home;
		logic gate;
	} enc_pins_s;

	// ************************************************
	// helpers
	// ************************************************
	// low bits of the prescaler that must all be ones for a tick
	function automatic logic [6:0] div_mask(input logic [2:0] code);
		div_mask = PRE_ONES >> (3'd7 - code);
	endfunction

	// {valid, down} for one sample pair of {a, b}
	function automatic logic [1:0] quad_step(input logic [1:0] prev, input logic [1:0] cur);
		logic [1:0] diff;
		diff = prev ^ cur;
		quad_step = {(diff == 2'b01) || (diff == 2'b10), prev[1] ^ cur[0]};
	endfunction

endpackage

/* File: rtl/enc_sync.sv */
// two-stage synchroniser for the encoder pins
module enc_sync
	import enc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire enc_pins_s raw_i,
	output enc_pins_s sync_o
);

	typedef struct packed {
		enc_pins_s meta;
		enc_pins_s stable;
	} enc_sync_s;

	enc_sync_s s;
	enc_sync_s next_s;

	// the first stage feeds only the second, so no decode sees a metastable level
	always_comb begin
		next_s.meta = raw_i;
		next_s.stable = s.meta;
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign sync_o = s.stable;

endmodule

/* File: rtl/enc_top.sv */
// incremental encoder interface core with its apb register slave
//
// The implementer's own choices: the register addresses and the APB register port.
module enc_top
	import enc_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire enc_apb_req_s apb_req_i,
	input wire enc_pins_s pins_i,
	input wire logic idle_i,
	output enc_apb_rsp_s apb_rsp_o
);

	// ************************************************
	// state
	// ************************************************
	typedef struct packed {
		logic [15:0] ctrl;
		logic [4:0] io;
		logic [31:0] pos;
		logic [31:0] idx_cnt;
		logic [31:0] timer;
		logic [31:0] ge;
		logic [31:0] lec;
		logic [15:0] vel;
		logic [6:0] pre;
		logic a_prev;
		logic b_prev;
		logic idx_prev;
		logic home_prev;
		logic arm;
		logic init_done;
		enc_home_e hm;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} enc_core_s;

	enc_core_s s;
	enc_core_s next_s;
	enc_pins_s pin;

	logic en;
	logic sidl;
	logic imv_a;
	logic imv_b;
	logic dirsel;
	logic gate_enable;
	logic timer_mode;
	logic run;
	logic tick;
	logic a_sw;
	logic b_sw;
	logic a_n;
	logic b_n;
	logic idx_n;
	logic home_n;
	logic match;
	logic idx_rise;
	logic home_rise;
	logic a_rise;
	logic idx_evt;
	logic cnt_raw;
	logic cnt_evt;
	logic cnt_down;
	logic wr;
	logic [1:0] step;
	logic [2:0] div;
	enc_pimod_e pimod;
	enc_ccm_e ccm;

	// ************************************************
	// input conditioning
	// ************************************************
	enc_sync u_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.raw_i(pins_i),
		.sync_o(pin)
	);

	// swap first, then invert, so the match compare sees decoder-side levels
	assign a_sw = s.io[IO_SWAP] ? pin.phase_b_input : pin.phase_a_input;
	assign b_sw = s.io[IO_SWAP] ? pin.phase_a_input : pin.phase_b_input;
	assign a_n = a_sw ^ s.io[IO_A_INV];
	assign b_n = b_sw ^ s.io[IO_B_INV];
	assign idx_n = pin.index ^ s.io[IO_IDX_INV];
	assign home_n = pin.home ^ s.io[IO_HOME_INV];

	// ************************************************
	// control decode
	// ************************************************
	assign en = s.ctrl[CTL_EN];
	assign sidl = s.ctrl[CTL_SIDL];
	assign imv_a = s.ctrl[CTL_IMV_A];
	assign imv_b = s.ctrl[CTL_IMV_B];
	assign dirsel = s.ctrl[CTL_DIRSEL];
	assign gate_enable = s.ctrl[CTL_GATE_ENABLE];
	assign div = s.ctrl[CTL_DIV_LSB +: 3];
	assign pimod = enc_pimod_e'(s.ctrl[CTL_PIMOD_LSB +: 3]);
	assign ccm = enc_ccm_e'(s.ctrl[CTL_CCM_LSB +: 2]);
	assign timer_mode = ccm[1];
	assign run = en & ~(sidl & idle_i);

	// prescaled tick; inputs are only looked at on ticks, hence the 2x rate advice
	assign tick = run & ((s.pre & div_mask(div)) == div_mask(div));

	// ************************************************
	// event decode
	// ************************************************
	assign step = quad_step({s.a_prev, s.b_prev}, {a_n, b_n});
	assign a_rise = tick & a_n & ~s.a_prev;
	assign idx_rise = tick & idx_n & ~s.idx_prev;
	assign home_rise = tick & home_n & ~s.home_prev;
	assign match = (a_n == imv_a) & (b_n == imv_b);
	// in quadrature mode an index counts only when both phases match
	assign idx_evt = idx_rise & ((ccm != CCM_QUAD) | match);

	// count source per mode
	assign cnt_raw = (ccm == CCM_QUAD) ? (tick & step[1]) :
		(ccm == CCM_INT_TMR) ? tick : a_rise;
	assign cnt_evt = cnt_raw & (~gate_enable | pin.gate);
	// direction select flips whatever direction the mode supplies
	assign cnt_down = dirsel ^ ((ccm == CCM_QUAD) ? step[0] :
		(ccm == CCM_EXT_DIR) ? ~b_n : 1'b0);

	// a write takes effect at the edge where the master sees pready
	assign wr = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite & s.pready;

	// ************************************************
	// next state
	// ************************************************
	always_comb begin
		next_s = s;

		// status clear goes first so a same-cycle hardware set wins
		if (wr && apb_req_i.paddr == ADDR_STAT && apb_req_i.pwdata[STAT_DONE]) begin
			next_s.init_done = 1'b0;
		end

		// counters run only while enabled and not stopped by idle
		if (run) begin
			next_s.pre = s.pre + 7'h01;
			if (tick) begin
				next_s.a_prev = a_n;
				next_s.b_prev = b_n;
				next_s.idx_prev = idx_n;
				next_s.home_prev = home_n;
			end
			if (cnt_evt) begin
				next_s.pos = cnt_down ? s.pos - 32'h1 : s.pos + 32'h1;
				next_s.vel = cnt_down ? s.vel - 16'h1 : s.vel + 16'h1;
			end
			// interval timer measures ticks between counts, or free-runs as a timer
			if (cnt_evt && !timer_mode) begin
				next_s.timer = COUNT_RESET;
			end else if (tick) begin
				next_s.timer = s.timer + 32'h1;
			end
			// index counter follows index events, or the count source in timer modes
			if (timer_mode ? cnt_evt : idx_evt) begin
				next_s.idx_cnt = cnt_down ? s.idx_cnt - 32'h1 : s.idx_cnt + 32'h1;
			end

			// position initialisation, skipped entirely in timer modes
			if (!timer_mode) begin
				if (home_rise) begin
					next_s.hm = HM_HOMED;
				end
				unique case (pimod)
					PIM_INDEX_RESET: begin
						if (idx_evt) begin
							next_s.pos = COUNT_RESET;
						end
					end
					PIM_NEXT: begin
						if (idx_evt && s.arm) begin
							next_s.pos = s.ge;
							next_s.arm = 1'b0;
							next_s.init_done = 1'b1;
						end
					end
					PIM_HOME_FIRST: begin
						if (idx_evt && s.hm == HM_HOMED) begin
							next_s.pos = s.ge;
							next_s.hm = HM_IDLE;
							next_s.init_done = 1'b1;
						end
					end
					PIM_HOME_SECOND: begin
						if (idx_evt && s.hm == HM_HOMED) begin
							next_s.hm = HM_ONE;
						end else if (idx_evt && s.hm == HM_ONE) begin
							next_s.pos = s.ge;
							next_s.hm = HM_IDLE;
							next_s.init_done = 1'b1;
						end
					end
					PIM_GE_RESET: begin
						if (cnt_evt && s.pos == s.ge) begin
							next_s.pos = COUNT_RESET;
						end
					end
					PIM_MODULO: begin
						// wraps between the low and high compare values
						if (cnt_evt && !cnt_down && s.pos == s.ge) begin
							next_s.pos = s.lec;
						end else if (cnt_evt && cnt_down && s.pos == s.lec) begin
							next_s.pos = s.ge;
						end
					end
					default: begin
						// none and the reserved code leave the counter alone
					end
				endcase
			end
		end

		// software writes win over hardware counting; allowed while halted
		if (wr) begin
			unique case (apb_req_i.paddr)
				ADDR_CTRL: begin
					next_s.ctrl = apb_req_i.pwdata[15:0] & CTRL_WMASK;
					next_s.arm = (apb_req_i.pwdata[CTL_PIMOD_LSB +: 3] == PIM_NEXT);
				end
				ADDR_IO: next_s.io = apb_req_i.pwdata[IO_LSB +: 5];
				ADDR_POS: next_s.pos = apb_req_i.pwdata;
				ADDR_IDX: next_s.idx_cnt = apb_req_i.pwdata;
				ADDR_TMR: next_s.timer = apb_req_i.pwdata;
				ADDR_VEL: next_s.vel = apb_req_i.pwdata[15:0];
				ADDR_INIT: next_s.ge = apb_req_i.pwdata;
				ADDR_LEC: next_s.lec = apb_req_i.pwdata;
				default: begin
					// status is clear-only, unmapped writes are dropped
				end
			endcase
		end

		// apb answer: one wait cycle, then pready for exactly one cycle
		next_s.pready = apb_req_i.psel & apb_req_i.penable & ~s.pready;
		next_s.pslverr = 1'b0;
		next_s.prdata = 32'h0000_0000;
		if (apb_req_i.psel && apb_req_i.penable && !s.pready) begin
			unique case (apb_req_i.paddr)
				ADDR_CTRL: next_s.prdata = {16'h0000, s.ctrl};
				ADDR_IO: next_s.prdata = {23'h000000, s.io, home_n, idx_n, b_n, a_n};
				ADDR_STAT: next_s.prdata = {27'h0000000, s.arm, s.hm, s.init_done};
				ADDR_POS: next_s.prdata = s.pos;
				ADDR_IDX: next_s.prdata = s.idx_cnt;
				ADDR_TMR: next_s.prdata = s.timer;
				ADDR_VEL: next_s.prdata = {16'h0000, s.vel};
				ADDR_INIT: next_s.prdata = s.ge;
				ADDR_LEC: next_s.prdata = s.lec;
				default: next_s.pslverr = 1'b1;
			endcase
		end
	end

	// ************************************************
	// registers
	// ************************************************
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			s <= '0;
			s.hm <= HM_IDLE;
		end else begin
			s <= next_s;
		end
	end

	assign apb_rsp_o.pready = s.pready;
	assign apb_rsp_o.pslverr = s.pslverr;
	assign apb_rsp_o.prdata = s.prdata;

	// ************************************************
	// checks
	// ************************************************
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_quiet_bus;
		!apb_req_i.psel;
	endsequence

	sequence s_div4_tick;
		(tick && div == 3'd2 && !apb_req_i.psel) ##1 (run && !apb_req_i.psel)[*4];
	endsequence

	sequence s_apb_access;
		apb_req_i.psel && apb_req_i.penable && !s.pready;
	endsequence

	a_halt_when_off: assert property (!en and s_quiet_bus |=> $stable(s.pos))
		else $error("position moved while disabled");

	a_idle_halts_pos: assert property (en && sidl && idle_i and s_quiet_bus |=> $stable(s.pos))
		else $error("position moved while stopped in idle");

	a_index_reset_pos: assert property (!timer_mode && pimod == PIM_INDEX_RESET && idx_evt
		and s_quiet_bus |=> s.pos == COUNT_RESET)
		else $error("index did not reset position");

	a_next_index_load: assert property (!timer_mode && pimod == PIM_NEXT && s.arm && idx_evt
		and s_quiet_bus |=> s.pos == $past(s.ge) && !s.arm && s.init_done)
		else $error("armed index did not load position");

	a_ge_match_reset: assert property (!timer_mode && pimod == PIM_GE_RESET && cnt_evt
		&& s.pos == s.ge and s_quiet_bus |=> s.pos == COUNT_RESET)
		else $error("equal compare did not reset position");

	a_quad_unit_step: assert property (ccm == CCM_QUAD && cnt_evt && pimod == PIM_NONE
		and s_quiet_bus |=> s.pos == $past(s.pos) + 32'h1 || s.pos == $past(s.pos) - 32'h1)
		else $error("quadrature step not one count");

	a_match_gates_index: assert property (ccm == CCM_QUAD && idx_rise && !match
		&& pimod == PIM_INDEX_RESET && !cnt_evt and s_quiet_bus |=> $stable(s.pos))
		else $error("unmatched index changed position");

	a_timer_ignores_init: assert property (ccm == CCM_INT_TMR && tick && !gate_enable && !dirsel
		and s_quiet_bus |=> s.pos == $past(s.pos) + 32'h1)
		else $error("timer mode did not count up by one");

	a_prescale_gap: assert property (s_div4_tick |-> tick)
		else $error("divide by four tick spacing wrong");

	a_apb_one_wait: assert property (s_apb_access |=> s.pready ##1 !s.pready)
		else $error("apb answer timing wrong");

endmodule

/* File: verification/enc_encoder_model.sv */
// behavioural incremental encoder that drives the phase, index, home and gate pins
module enc_encoder_model
	import enc_pkg::*;
#(
	parameter int HOLD = 6
)
(
	input wire logic clk_i,
	output enc_pins_s pins_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// ************************************************
	// pin drive
	// ************************************************
	// all pins start low, shaft at rest
	initial begin
		pins_o = '0;
	end

	// each level stands several counter clocks so no edge outruns the sampler
	task automatic hold_it();
		repeat (HOLD) @(posedge clk_i);
	endtask

	// one quadrature step: a leads b when moving up
	task automatic step(input logic up);
		@(posedge clk_i);
		if (up) begin
			pins_o.phase_a_input <= ~pins_o.phase_b_input;
			pins_o.phase_b_input <= pins_o.phase_a_input;
		end else begin
			pins_o.phase_a_input <= pins_o.phase_b_input;
			pins_o.phase_b_input <= ~pins_o.phase_a_input;
		end
		hold_it();
	endtask

	// raw phase levels for the external count modes, {a, b}
	task automatic set_ab(input logic [1:0] v);
		@(posedge clk_i);
		{pins_o.phase_a_input, pins_o.phase_b_input} <= v;
		hold_it();
	endtask

	// single index mark
	task automatic idx_pulse();
		@(posedge clk_i);
		pins_o.index <= ~pins_o.index;
		hold_it();
		pins_o.index <= ~pins_o.index;
		hold_it();
	endtask

	// single home switch pass
	task automatic home_pulse();
		@(posedge clk_i);
		pins_o.home <= ~pins_o.home;
		hold_it();
		pins_o.home <= ~pins_o.home;
		hold_it();
	endtask

	// gate level, high lets counting through
	task automatic set_gate(input logic g);
		@(posedge clk_i);
		pins_o.gate <= g;
		hold_it();
	endtask
endmodule

/* File: verification/test_incremental_encoder_interface.sv */
// register level testbench for the encoder interface core
module test_incremental_encoder_interface
	import enc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk_i = 1'b0;
	logic rst_n_i;
	logic idle;
	enc_apb_req_s req;
	enc_apb_rsp_s rsp;
	enc_pins_s pins;
	int n_errors = 0;
	int cmp_count = 0;

	// ************************************************
	// clock, design and encoder
	// ************************************************
	always #4 clk_i = ~clk_i;

	enc_top uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .apb_req_i(req), .pins_i(pins),
		.idle_i(idle), .apb_rsp_o(rsp));

	enc_encoder_model enc (.clk_i(clk_i), .pins_o(pins));

	// ************************************************
	// bus and check tasks
	// ************************************************
	task automatic stop_test();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic bad(input string s);
		n_errors++;
		$display("BAD %0t %s", $time, s);
	endtask

	// setup cycle, then access held until pready is seen at an edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge clk_i);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge clk_i);
		req.penable <= 1'b1;
		// no own limit: only the watchdog ends a wait for pready
		do begin
			@(posedge clk_i);
		end while (rsp.pready !== 1'b1);
		q = rsp.prdata;
		e = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) bad($sformatf("got %h want %h", got, exp));
	endtask

	task automatic rng(input logic [31:0] got, input int lo, input int hi);
		cmp_count++;
		// an unknown value must not slip through as a pass
		if ((got >= 32'(lo) && got <= 32'(hi)) !== 1'b1) bad($sformatf("got %0d", got));
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		xfer(1'b1, a, d, q, e);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic e;
		xfer(1'b0, a, '0, q, e);
		chk(q, exp);
	endtask

	task automatic steps(input int n, input logic up);
		repeat (n) enc.step(up);
	endtask

	task automatic done(input string s);
		$display("test %s finished", s);
	endtask

	// ************************************************
	// test sequence
	// ************************************************
	// hang guard, far beyond the expected run of about 9k cycles
	initial begin
		#200000;
		bad("watchdog");
		stop_test();
	end

	initial begin
		logic [31:0] q;
		logic x;
		rst_n_i <= 1'b0;
		idle <= 1'b0;
		req <= '0;
		repeat (12) @(posedge clk_i);
		rst_n_i <= 1'b1;
		// reset values, reserved bits, unmapped word, disabled counters
		rd(ADDR_CTRL, 32'h0);
		rd(ADDR_POS, 32'h0);
		wr(ADDR_CTRL, 32'h7fff);
		rd(ADDR_CTRL, 32'h3f7f);
		xfer(1'b0, 8'h40, '0, q, x);
		chk({31'h0, x}, 32'h1);
		chk(q, 32'h0);
		wr(ADDR_POS, 32'h5);
		steps(1, 1'b1);
		steps(1, 1'b0);
		rd(ADDR_POS, 32'h5);
		rd(ADDR_TMR, 32'h0);
		done("registers");
		// x4 decode both ways, direction select, stop in idle
		wr(ADDR_CTRL, 32'h0);
		wr(ADDR_POS, 32'h0);
		wr(ADDR_CTRL, 32'h8000);
		steps(4, 1'b1);
		rd(ADDR_POS, 32'h4);
		steps(6, 1'b0);
		rd(ADDR_POS, 32'hffff_fffe);
		wr(ADDR_CTRL, 32'h8008);
		steps(2, 1'b1);
		rd(ADDR_POS, 32'hffff_fffc);
		wr(ADDR_CTRL, 32'ha000);
		idle <= 1'b1;
		steps(1, 1'b1);
		steps(1, 1'b0);
		rd(ADDR_POS, 32'hffff_fffc);
		wr(ADDR_CTRL, 32'h8000);
		steps(1, 1'b1);
		rd(ADDR_POS, 32'hffff_fffd);
		idle <= 1'b0;
		done("quadrature");
		// phases now at a=1 b=0: index match and init modes
		wr(ADDR_CTRL, 32'h8500);
		enc.idx_pulse();
		rd(ADDR_POS, 32'h0);
		wr(ADDR_POS, 32'h7);
		wr(ADDR_CTRL, 32'h8600);
		enc.idx_pulse();
		rd(ADDR_POS, 32'h7);
		wr(ADDR_CTRL, 32'h8100);
		enc.idx_pulse();
		rd(ADDR_POS, 32'h7);
		wr(ADDR_INIT, 32'h1234_5678);
		wr(ADDR_CTRL, 32'h8900);
		enc.idx_pulse();
		rd(ADDR_POS, 32'h1234_5678);
		wr(ADDR_POS, 32'h3);
		enc.idx_pulse();
		rd(ADDR_POS, 32'h3);
		wr(ADDR_CTRL, 32'h8d00);
		enc.idx_pulse();
		rd(ADDR_POS, 32'h3);
		enc.home_pulse();
		enc.idx_pulse();
		rd(ADDR_POS, 32'h1234_5678);
		wr(ADDR_POS, 32'h3);
		wr(ADDR_CTRL, 32'h9100);
		enc.home_pulse();
		enc.idx_pulse();
		rd(ADDR_POS, 32'h3);
		enc.idx_pulse();
		rd(ADDR_POS, 32'h1234_5678);
		// homing complete flag set, home state back to idle, then write one clears
		rd(ADDR_STAT, 32'h3);
		wr(ADDR_STAT, 32'h1);
		rd(ADDR_STAT, 32'h2);
		done("index");
		// compare reset at the high register, then modulo between low and high
		wr(ADDR_INIT, 32'h2);
		wr(ADDR_POS, 32'h0);
		wr(ADDR_CTRL, 32'h9400);
		steps(2, 1'b1);
		rd(ADDR_POS, 32'h2);
		steps(1, 1'b1);
		rd(ADDR_POS, 32'h0);
		wr(ADDR_LEC, 32'h1);
		wr(ADDR_CTRL, 32'h9800);
		steps(3, 1'b1);
		rd(ADDR_POS, 32'h1);
		steps(1, 1'b0);
		rd(ADDR_POS, 32'h2);
		done("compare");
		// external direction on b, then gated external clock on a
		wr(ADDR_POS, 32'h0);
		wr(ADDR_CTRL, 32'h8001);
		enc.set_ab(2'b01);
		enc.set_ab(2'b11);
		rd(ADDR_POS, 32'h1);
		enc.set_ab(2'b00);
		enc.set_ab(2'b10);
		rd(ADDR_POS, 32'h0);
		wr(ADDR_CTRL, 32'h8006);
		enc.set_ab(2'b00);
		enc.set_gate(1'b0);
		enc.set_ab(2'b10);
		rd(ADDR_POS, 32'h0);
		enc.set_ab(2'b00);
		enc.set_gate(1'b1);
		enc.set_ab(2'b10);
		rd(ADDR_POS, 32'h1);
		done("external");
		// internal timer at every prescale code, init mode bits set but ignored
		for (int n = 0; n < 8; n++) begin
			wr(ADDR_CTRL, 32'h0);
			wr(ADDR_TMR, 32'h0);
			wr(ADDR_POS, 32'h0);
			wr(ADDR_IDX, 32'h0);
			wr(ADDR_VEL, 32'h0);
			wr(ADDR_CTRL, 32'h8403 | 32'(n << 4));
			repeat (1024) @(posedge clk_i);
			wr(ADDR_CTRL, 32'h0);
			xfer(1'b0, ADDR_TMR, '0, q, x);
			rng(q, 1024 >> n, (1024 >> n) + 4);
			xfer(1'b0, ADDR_POS, '0, q, x);
			rng(q, 1024 >> n, (1024 >> n) + 4);
			xfer(1'b0, ADDR_IDX, '0, q, x);
			rng(q, 1024 >> n, (1024 >> n) + 4);
			xfer(1'b0, ADDR_VEL, '0, q, x);
			rng(q, 1024 >> n, (1024 >> n) + 4);
		end
		done("prescale");
		// pins rest at a=1 b=0, index and home low; module halted so no events
		wr(ADDR_IO, 32'h10);
		rd(ADDR_IO, 32'h12);
		wr(ADDR_IO, 32'h1f0);
		rd(ADDR_IO, 32'h1fd);
		done("io");
		stop_test();
	end
endmodule
